// ### shared/core_flags_pkg.sv
// Purpose: Shared constants and types for the core flag and interrupt register bank.
// Assumes: Register indices are data-memory addresses; the APB byte address is four times them.
// Notes: All reset values are zero.
`default_nettype none

package core_flags_pkg;

  // ---------------------------------------------------------------------
  // Data-memory register indices
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_WIN0 = 8'h00;
  localparam logic [7:0] IDX_PTR0 = 8'h01;
  localparam logic [7:0] IDX_WIN1 = 8'h02;
  localparam logic [7:0] IDX_PTR1 = 8'h03;
  localparam logic [7:0] IDX_BANK = 8'h04;
  localparam logic [7:0] IDX_WREG = 8'h05;
  localparam logic [7:0] IDX_FLAGS = 8'h0a;
  localparam logic [7:0] IDX_IRQ = 8'h0b;
  localparam logic [7:0] IDX_GP_BASE = 8'h20;
  localparam int GP_DEPTH = 224;

  // ---------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------
  localparam int PADDR_W = 12;

  // ---------------------------------------------------------------------
  // Flag register fields
  // ---------------------------------------------------------------------
  localparam int FLG_CARRY = 0;
  localparam int FLG_HALF = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_WRAP = 3;
  localparam int FLG_SLEEP = 4;
  localparam int FLG_WDOG = 5;
  localparam logic [5:0] FLAGS_SW_MASK = 6'h0f;
  localparam logic [5:0] FLAGS_RST = 6'h00;

  // ---------------------------------------------------------------------
  // Interrupt gate register fields
  // ---------------------------------------------------------------------
  localparam int IRQ_GLOBAL = 0;
  localparam int IRQ_PIN_EN = 1;
  localparam int IRQ_T0_EN = 2;
  localparam int IRQ_T1_EN = 3;
  localparam int IRQ_PIN_PEND = 4;
  localparam int IRQ_T0_PEND = 5;
  localparam int IRQ_T1_PEND = 6;
  localparam logic [6:0] IRQ_RST = 7'h00;

  // ---------------------------------------------------------------------
  // Interrupt vectors
  // ---------------------------------------------------------------------
  localparam logic [7:0] VEC_PIN = 8'h04;
  localparam logic [7:0] VEC_TMR0 = 8'h08;
  localparam logic [7:0] VEC_TMR1 = 8'h0c;

  // ---------------------------------------------------------------------
  // Execution unit operations
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_ADC = 4'h1,
    OP_SUB = 4'h2,
    OP_SBC = 4'h3,
    OP_AND = 4'h4,
    OP_OR = 4'h5,
    OP_XOR = 4'h6,
    OP_CPL = 4'h7,
    OP_RL = 4'h8,
    OP_RR = 4'h9,
    OP_RLC = 4'ha,
    OP_RRC = 4'hb,
    OP_INC = 4'hc,
    OP_DEC = 4'hd,
    OP_LOAD = 4'he,
    OP_STORE = 4'hf
  } alu_op_type;

endpackage

`default_nettype wire

// ### src/core_flags_and_irq_control.sv
// Purpose: Core special registers: indirect windows, pointers, working register, ALU flags,
//          interrupt gate register and interrupt acknowledge, with an APB register port.
// Assumes: All inputs synchronous to mclk; execution-unit strobes are one-cycle pulses.
// Notes: The rules of behaviour are listed below.
`timescale 1ns/10ps
`default_nettype none

module core_flags_and_irq_control
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [core_flags_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Execution unit operation port
  input wire logic alu_valid,
  input wire logic [3:0] alu_opcode,
  input wire logic [7:0] alu_addr,
  input wire logic [7:0] alu_imm,
  input wire logic alu_use_imm,
  input wire logic alu_to_mem,
  // Execution unit events
  input wire logic instr_boundary,
  input wire logic stack_full,
  input wire logic sleep_op,
  input wire logic watchdog_kick_op,
  input wire logic irq_exit_op,
  input wire logic subroutine_exit_op,
  // Peripheral events
  input wire logic ext_irq_pin_n,
  input wire logic tmr0_overflow,
  input wire logic tmr1_overflow,
  input wire logic watchdog_timeout,
  // Core outputs
  output logic irq_ack,
  output logic [7:0] irq_vector,
  output logic wake_req,
  output logic [7:0] working_value,
  output logic [7:0] flags_value
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0][core_flags_pkg::GP_DEPTH-1:0][7:0] gp;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic bank;
    logic [7:0] wreg;
    logic [5:0] flags;
    logic [6:0] irq;
    logic pin_low;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq_ack;
    logic [7:0] irq_vector;
    logic wake_req;
  } state_type;

  state_type state_ff;
  state_type nxt_state;

  // -----------------------------------------------------------------------
  // Address helpers
  // -----------------------------------------------------------------------
  // Resolves window 1 to {bank, ptr1} and window 0 to {0, ptr0}; other addresses go to bank 0.
  function automatic logic [8:0] resolve(input state_type s, input logic [7:0] a);
    logic [8:0] r;
    r = {1'b0, a};
    if (a == core_flags_pkg::IDX_WIN0)
    begin
      r = {1'b0, s.ptr0};
    end
    else if (a == core_flags_pkg::IDX_WIN1)
    begin
      r = {s.bank, s.ptr1};
    end
    return r;
  endfunction

  function automatic logic is_window(input logic [7:0] a);
    return (a == core_flags_pkg::IDX_WIN0) || (a == core_flags_pkg::IDX_WIN1);
  endfunction

  // Reads a resolved byte; a window reached through a pointer reads zero.
  function automatic logic [7:0] peek(input state_type s, input logic [8:0] ra);
    logic [7:0] a;
    logic [7:0] gi;
    logic [7:0] d;
    a = ra[7:0];
    gi = a - core_flags_pkg::IDX_GP_BASE;
    d = 8'h00;
    if (is_window(a))
    begin
      d = 8'h00;
    end
    else if (a >= core_flags_pkg::IDX_GP_BASE)
    begin
      d = s.gp[ra[8]][gi];
    end
    else
    begin
      case (a)
        core_flags_pkg::IDX_PTR0: d = s.ptr0;
        core_flags_pkg::IDX_PTR1: d = s.ptr1;
        core_flags_pkg::IDX_BANK: d = {7'h00, s.bank};
        core_flags_pkg::IDX_WREG: d = s.wreg;
        core_flags_pkg::IDX_FLAGS: d = {2'b00, s.flags};
        core_flags_pkg::IDX_IRQ: d = {1'b0, s.irq};
        default: d = 8'h00;
      endcase
    end
    return d;
  endfunction

  // Writes a resolved byte; a window reached through a pointer ignores the write.
  function automatic state_type poke(input state_type s, input logic [8:0] ra,
                                     input logic [7:0] d);
    state_type t;
    logic [7:0] a;
    logic [7:0] gi;
    t = s;
    a = ra[7:0];
    gi = a - core_flags_pkg::IDX_GP_BASE;
    if (is_window(a))
    begin
      t = s;
    end
    else if (a >= core_flags_pkg::IDX_GP_BASE)
    begin
      t.gp[ra[8]][gi] = d;
    end
    else
    begin
      case (a)
        core_flags_pkg::IDX_PTR0: t.ptr0 = d;
        core_flags_pkg::IDX_PTR1: t.ptr1 = d;
        core_flags_pkg::IDX_BANK: t.bank = d[0];
        core_flags_pkg::IDX_WREG: t.wreg = d;
        core_flags_pkg::IDX_FLAGS:
          t.flags = (s.flags & ~core_flags_pkg::FLAGS_SW_MASK)
                  | (d[5:0] & core_flags_pkg::FLAGS_SW_MASK);
        core_flags_pkg::IDX_IRQ: t.irq = d[6:0];
        default: t = s;
      endcase
    end
    return t;
  endfunction

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  localparam int PADDR_HI = core_flags_pkg::PADDR_W - 1;

  logic apb_access;
  logic apb_bad;
  logic [7:0] apb_idx;
  core_flags_pkg::alu_op_type op;
  logic [8:0] alu_ra;
  logic [7:0] opa;
  logic [7:0] opb;
  logic [7:0] addend;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] low5;
  logic [7:0] low8;
  logic [7:0] res;
  logic [5:0] nf;
  logic pin_fall;
  logic [2:0] ready_src;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.irq_ack = 1'b0;
    apb_access = psel & penable;
    apb_idx = paddr[9:2];
    apb_bad = (paddr[PADDR_HI:10] != '0) || (paddr[1:0] != 2'b00);
    op = core_flags_pkg::alu_op_type'(alu_opcode);
    alu_ra = resolve(state_ff, alu_addr);
    opa = state_ff.wreg;
    opb = alu_use_imm ? alu_imm : peek(state_ff, alu_ra);
    cin = 1'b0;
    addend = opb;
    sum9 = 9'h000;
    low5 = 5'h00;
    low8 = 8'h00;
    res = opb;
    nf = state_ff.flags;
    pin_fall = 1'b0;
    ready_src = 3'b000;

    // ---------------------------------------------------------------------
    // APB: one wait cycle, then pready; writes land on the pready edge.
    // ---------------------------------------------------------------------
    nxt_state.pready = apb_access & ~state_ff.pready;
    if (apb_access & ~state_ff.pready)
    begin
      nxt_state.pslverr = apb_bad;
      nxt_state.prdata = apb_bad ? 32'h0000_0000
                                 : {24'h00_0000, peek(state_ff, resolve(state_ff, apb_idx))};
    end
    if (apb_access & state_ff.pready & pwrite & ~state_ff.pslverr)
    begin
      nxt_state = poke(nxt_state, resolve(state_ff, apb_idx), pwdata[7:0]);
    end

    // ---------------------------------------------------------------------
    // ALU: operand A is the working register (operand B for INC and DEC), operand B immediate or memory.
    // ---------------------------------------------------------------------
    if (alu_valid)
    begin
      case (op)
        core_flags_pkg::OP_ADD, core_flags_pkg::OP_ADC,
        core_flags_pkg::OP_SUB, core_flags_pkg::OP_SBC,
        core_flags_pkg::OP_INC, core_flags_pkg::OP_DEC:
        begin
          // Subtraction adds the complement, so carry out means no borrow.
          case (op)
            core_flags_pkg::OP_ADD:
            begin
              addend = opb;
              cin = 1'b0;
            end
            core_flags_pkg::OP_ADC:
            begin
              addend = opb;
              cin = state_ff.flags[core_flags_pkg::FLG_CARRY];
            end
            core_flags_pkg::OP_SUB:
            begin
              addend = ~opb;
              cin = 1'b1;
            end
            core_flags_pkg::OP_SBC:
            begin
              addend = ~opb;
              cin = state_ff.flags[core_flags_pkg::FLG_CARRY];
            end
            core_flags_pkg::OP_INC:
            begin
              opa = opb;
              addend = 8'h01;
              cin = 1'b0;
            end
            default:
            begin
              opa = opb;
              addend = 8'hff;
              cin = 1'b0;
            end
          endcase
          sum9 = {1'b0, opa} + {1'b0, addend} + {8'h00, cin};
          low5 = {1'b0, opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
          low8 = {1'b0, opa[6:0]} + {1'b0, addend[6:0]} + {7'h00, cin};
          res = sum9[7:0];
          nf[core_flags_pkg::FLG_ZERO] = (res == 8'h00);
          if ((op != core_flags_pkg::OP_INC) && (op != core_flags_pkg::OP_DEC))
          begin
            nf[core_flags_pkg::FLG_CARRY] = sum9[8];
            nf[core_flags_pkg::FLG_HALF] = low5[4];
            nf[core_flags_pkg::FLG_WRAP] = low8[7] ^ sum9[8];
          end
        end
        core_flags_pkg::OP_AND, core_flags_pkg::OP_OR,
        core_flags_pkg::OP_XOR, core_flags_pkg::OP_CPL:
        begin
          case (op)
            core_flags_pkg::OP_AND: res = opa & opb;
            core_flags_pkg::OP_OR: res = opa | opb;
            core_flags_pkg::OP_XOR: res = opa ^ opb;
            default: res = ~opb;
          endcase
          nf[core_flags_pkg::FLG_ZERO] = (res == 8'h00);
        end
        core_flags_pkg::OP_RL: res = {opb[6:0], opb[7]};
        core_flags_pkg::OP_RR: res = {opb[0], opb[7:1]};
        core_flags_pkg::OP_RLC:
        begin
          res = {opb[6:0], state_ff.flags[core_flags_pkg::FLG_CARRY]};
          nf[core_flags_pkg::FLG_CARRY] = opb[7];
        end
        core_flags_pkg::OP_RRC:
        begin
          res = {state_ff.flags[core_flags_pkg::FLG_CARRY], opb[7:1]};
          nf[core_flags_pkg::FLG_CARRY] = opb[0];
        end
        core_flags_pkg::OP_LOAD: res = opb;
        default: res = state_ff.wreg;
      endcase
      // Moves between memory locations go through the working register.
      if ((op == core_flags_pkg::OP_STORE) || (alu_to_mem && !alu_use_imm))
      begin
        nxt_state = poke(nxt_state, alu_ra, res);
      end
      else
      begin
        nxt_state.wreg = res;
      end
      nxt_state.flags[3:0] = nf[3:0];
    end

    // ---------------------------------------------------------------------
    // Sleep and watchdog flags; a timeout wins over a clear in its cycle.
    // ---------------------------------------------------------------------
    if (watchdog_kick_op)
    begin
      nxt_state.flags[core_flags_pkg::FLG_SLEEP] = 1'b0;
      nxt_state.flags[core_flags_pkg::FLG_WDOG] = 1'b0;
    end
    if (sleep_op)
    begin
      nxt_state.flags[core_flags_pkg::FLG_SLEEP] = 1'b1;
      nxt_state.flags[core_flags_pkg::FLG_WDOG] = 1'b0;
    end
    if (watchdog_timeout)
    begin
      nxt_state.flags[core_flags_pkg::FLG_WDOG] = 1'b1;
    end

    // ---------------------------------------------------------------------
    // Interrupts.
    // ---------------------------------------------------------------------
    nxt_state.pin_low = ~ext_irq_pin_n;
    pin_fall = ~state_ff.pin_low & ~ext_irq_pin_n;
    if (irq_exit_op)
    begin
      nxt_state.irq[core_flags_pkg::IRQ_GLOBAL] = 1'b1;
    end
    if (subroutine_exit_op && !irq_exit_op)
    begin
      // A plain return leaves the gate as it stands.
      nxt_state.irq[core_flags_pkg::IRQ_GLOBAL] = nxt_state.irq[core_flags_pkg::IRQ_GLOBAL];
    end
    ready_src = state_ff.irq[6:4] & state_ff.irq[3:1];
    if (instr_boundary && !stack_full && state_ff.irq[core_flags_pkg::IRQ_GLOBAL]
        && (ready_src != 3'b000))
    begin
      // The core pushes only the program counter on this pulse.
      nxt_state.irq_ack = 1'b1;
      nxt_state.irq[core_flags_pkg::IRQ_GLOBAL] = 1'b0;
      if (ready_src[0])
      begin
        nxt_state.irq[core_flags_pkg::IRQ_PIN_PEND] = 1'b0;
        nxt_state.irq_vector = core_flags_pkg::VEC_PIN;
      end
      else if (ready_src[1])
      begin
        nxt_state.irq[core_flags_pkg::IRQ_T0_PEND] = 1'b0;
        nxt_state.irq_vector = core_flags_pkg::VEC_TMR0;
      end
      else
      begin
        nxt_state.irq[core_flags_pkg::IRQ_T1_PEND] = 1'b0;
        nxt_state.irq_vector = core_flags_pkg::VEC_TMR1;
      end
    end
    // New requests set after every clear so none is lost.
    if (pin_fall)
    begin
      nxt_state.irq[core_flags_pkg::IRQ_PIN_PEND] = 1'b1;
    end
    if (tmr0_overflow)
    begin
      nxt_state.irq[core_flags_pkg::IRQ_T0_PEND] = 1'b1;
    end
    if (tmr1_overflow)
    begin
      nxt_state.irq[core_flags_pkg::IRQ_T1_PEND] = 1'b1;
    end
    nxt_state.wake_req = |(nxt_state.irq[6:4] & nxt_state.irq[3:1]);
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign prdata = state_ff.prdata;
  assign pready = state_ff.pready;
  assign pslverr = state_ff.pslverr;
  assign irq_ack = state_ff.irq_ack;
  assign irq_vector = state_ff.irq_vector;
  assign wake_req = state_ff.wake_req;
  assign working_value = state_ff.wreg;
  assign flags_value = {2'b00, state_ff.flags};

endmodule

`default_nettype wire

// ### verif/core_flags_and_irq_control_assertions.sv
// Purpose: Property checks on the core flag and interrupt register bank.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to every instance of the design.
`timescale 1ns/10ps
`default_nettype none

module core_flags_and_irq_control_assertions
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  // Execution unit and events
  input wire logic alu_valid,
  input wire logic instr_boundary,
  input wire logic stack_full,
  input wire logic sleep_op,
  input wire logic watchdog_kick_op,
  input wire logic watchdog_timeout,
  // Core outputs
  input wire logic irq_ack,
  input wire logic [7:0] irq_vector,
  input wire logic [7:0] flags_value
);
  default clocking dflt @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_ready_wait: assert property (
    psel && penable && !pready |=> pready) else $error("Register port answer late.");
  a_flags_top_zero: assert property (
    flags_value[7:6] == 2'b00) else $error("Unused flag bits not zero.");
  a_kick_clears: assert property (
    watchdog_kick_op && !sleep_op && !watchdog_timeout |=> flags_value[5:4] == 2'b00)
    else $error("Kick left power flags set.");
  a_sleep_marks: assert property (
    sleep_op && !watchdog_kick_op && !watchdog_timeout |=> flags_value[5:4] == 2'b01)
    else $error("Sleep flags wrong.");
  a_timeout_marks: assert property (
    watchdog_timeout |=> flags_value[5]) else $error("Timeout flag not set.");
  a_ack_gated: assert property (
    irq_ack |-> $past(instr_boundary) && !$past(stack_full))
    else $error("Acknowledge outside boundary or with full stack.");
  a_vector_legal: assert property (
    irq_ack |-> irq_vector inside {8'h04, 8'h08, 8'h0c}) else $error("Bad vector.");
  a_ack_single: assert property (
    irq_ack |=> !irq_ack) else $error("Second acknowledge with gate closed.");
  a_flags_hold: assert property (
    !(alu_valid || sleep_op || watchdog_kick_op || watchdog_timeout ||
    (psel && penable && pwrite)) |=> $stable(flags_value)) else $error("Flags moved alone.");

  c_ack_pin: cover property (irq_ack && irq_vector == 8'h04);
  c_ack_blocked: cover property (instr_boundary && stack_full);
  c_alu: cover property (alu_valid);
endmodule

bind core_flags_and_irq_control core_flags_and_irq_control_assertions
  core_flags_and_irq_control_assertions_inst (.mclk(mclk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .alu_valid(alu_valid),
  .instr_boundary(instr_boundary), .stack_full(stack_full), .sleep_op(sleep_op),
  .watchdog_kick_op(watchdog_kick_op), .watchdog_timeout(watchdog_timeout),
  .irq_ack(irq_ack), .irq_vector(irq_vector), .flags_value(flags_value));

`default_nettype wire

// ### verif/core_flags_and_irq_control_bench.sv
// Purpose: Self-checking bench for the core flag and interrupt register bank.
// Assumes: Register port answers after one wait state.
// Notes: Arithmetic operands come from a fixed-seed shift register, except 8'h80 plus 8'h80 in the first step and W minus itself in the second.
`timescale 1ns/10ps
`default_nettype none

module core_flags_and_irq_control_bench;
  logic mclk, arst_n, psel, penable, pwrite, alu_valid, alu_use_imm, alu_to_mem;
  logic instr_boundary, stack_full, subroutine_exit_op, ext_irq_pin_n;
  logic pready, pslverr, irq_ack, wake_req, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, rnd;
  logic [3:0] alu_opcode;
  logic [7:0] alu_addr, alu_imm, irq_vector, working_value, flags_value, w, b;
  logic [5:0] ev;
  logic [11:0] x;
  int bad_count, samples_checked, cycles;

`define CHK(nm, exp, got) \
  begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

  core_flags_and_irq_control core_flags_and_irq_control_inst (.mclk(mclk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alu_valid(alu_valid),
    .alu_opcode(alu_opcode), .alu_addr(alu_addr), .alu_imm(alu_imm),
    .alu_use_imm(alu_use_imm), .alu_to_mem(alu_to_mem), .instr_boundary(instr_boundary),
    .stack_full(stack_full), .sleep_op(ev[1]), .watchdog_kick_op(ev[0]),
    .irq_exit_op(ev[5]), .subroutine_exit_op(subroutine_exit_op),
    .ext_irq_pin_n(ext_irq_pin_n), .tmr0_overflow(ev[3]), .tmr1_overflow(ev[4]),
    .watchdog_timeout(ev[2]), .irq_ack(irq_ack), .irq_vector(irq_vector),
    .wake_req(wake_req), .working_value(working_value), .flags_value(flags_value));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Result and {wrap, zero, half, carry} of W plus or minus B.
  function automatic logic [11:0] arith(input logic [7:0] wa, input logic [7:0] ba,
                                        input logic sub);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    bb = sub ? ~ba : ba;
    s = {1'b0, wa} + {1'b0, bb} + {8'h00, sub};
    h = {1'b0, wa[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    l = {1'b0, wa[6:0]} + {1'b0, bb[6:0]} + {7'h00, sub};
    return {s[7:0], l[7] ^ s[8], s[7:0] == 8'h00, h[4], s[8]};
  endfunction

  task automatic results();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic alu(input core_flags_pkg::alu_op_type op, input logic [7:0] imm);
    @(posedge mclk);
    alu_valid <= 1'b1;
    alu_opcode <= op;
    alu_imm <= imm;
    @(posedge mclk);
    alu_valid <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 6'h00;
    @(negedge mclk);
  endtask

  task automatic ack(input logic [7:0] v);
    int n;
    n = 0;
    while (irq_ack !== 1'b1 && n < 8)
    begin
      @(negedge mclk);
      n++;
    end
    `CHK("ack vector", {1'b1, v}, {irq_ack, irq_vector})
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      results();
    end
  end

  initial
  begin
    {psel, penable, pwrite, alu_valid, alu_to_mem, instr_boundary, stack_full} = '0;
    {subroutine_exit_op, arst_n, ev, paddr, pwdata, alu_opcode, alu_addr, alu_imm} = '0;
    alu_use_imm = 1'b1;
    ext_irq_pin_n = 1'b1;
    rnd = 32'h11600653;
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, 12'h02c, 8'h00);
    `CHK("gate reset", 32'h0, q)
    for (int i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      w = (i == 0) ? 8'h80 : rnd[7:0];
      b = (i < 2) ? w : rnd[15:8];
      apb(1'b1, 12'h014, w);
      alu(i[0] ? core_flags_pkg::OP_SUB : core_flags_pkg::OP_ADD, b);
      x = arith(w, b, i[0]);
      `CHK("result", x[11:4], working_value)
      `CHK("flags", x[3:0], flags_value[3:0])
    end
    apb(1'b0, 12'h014, 8'h00);
    `CHK("working map", {24'h0, x[11:4]}, q)
    apb(1'b1, 12'h004, 8'h30);
    apb(1'b1, 12'h000, rnd[23:16]);
    apb(1'b0, 12'h0c0, 8'h00);
    `CHK("via pointer0", {24'h0, rnd[23:16]}, q)
    apb(1'b1, 12'h00c, 8'h30);
    apb(1'b1, 12'h010, 8'h01);
    apb(1'b1, 12'h008, ~rnd[23:16]);
    apb(1'b0, 12'h008, 8'h00);
    `CHK("via pointer1", {24'h0, ~rnd[23:16]}, q)
    apb(1'b0, 12'h0c0, 8'h00);
    `CHK("bank0 kept", {24'h0, rnd[23:16]}, q)
    alu_use_imm <= 1'b0;
    alu_to_mem <= 1'b1;
    alu(core_flags_pkg::OP_INC, 8'h00);
    b = rnd[23:16] + 8'h01;
    apb(1'b0, 12'h0c0, 8'h00);
    `CHK("inc via window", {24'h0, b}, q)
    `CHK("inc zero", (b == 8'h00), flags_value[2])
    apb(1'b1, 12'h028, 8'h01);
    alu_to_mem <= 1'b0;
    alu(core_flags_pkg::OP_RRC, 8'h00);
    `CHK("rrc", {b[0], 1'b1, b[7:1]}, {flags_value[0], working_value})
    apb(1'b1, 12'h004, 8'h00);
    apb(1'b0, 12'h000, 8'h00);
    `CHK("self window", 32'h0, q)
    apb(1'b0, 12'h018, 8'h00);
    `CHK("unused index", 33'h0, {e, q})
    apb(1'b0, 12'h029, 8'h00);
    `CHK("misaligned", 1'b1, e)
    pulse(6'h04);
    `CHK("timeout", 2'b10, flags_value[5:4])
    pulse(6'h02);
    `CHK("sleep", 2'b01, flags_value[5:4])
    apb(1'b1, 12'h028, 8'hf0);
    apb(1'b0, 12'h028, 8'h00);
    `CHK("flag write", 32'h10, q)
    pulse(6'h01);
    `CHK("kick", 2'b00, flags_value[5:4])
    apb(1'b1, 12'h02c, 8'h0f);
    stack_full <= 1'b1;
    pulse(6'h18);
    apb(1'b0, 12'h02c, 8'h00);
    `CHK("pending", 32'h6f, q)
    `CHK("wake", 1'b1, wake_req)
    instr_boundary <= 1'b1;
    repeat (4) @(negedge mclk);
    `CHK("stack full", 1'b0, irq_ack)
    @(posedge mclk);
    stack_full <= 1'b0;
    ack(8'h08);
    @(posedge mclk);
    subroutine_exit_op <= 1'b1;
    @(posedge mclk);
    subroutine_exit_op <= 1'b0;
    apb(1'b0, 12'h02c, 8'h00);
    `CHK("after ack", 32'h4e, q)
    apb(1'b1, 12'h02c, 8'h4f);
    ack(8'h0c);
    @(posedge mclk);
    instr_boundary <= 1'b0;
    ext_irq_pin_n <= 1'b0;
    pulse(6'h28);
    apb(1'b0, 12'h02c, 8'h00);
    `CHK("pin pending", 32'h3f, q)
    instr_boundary <= 1'b1;
    ack(8'h04);
    apb(1'b0, 12'h02c, 8'h00);
    `CHK("pin cleared", 32'h2e, q)
    apb(1'b1, 12'h02c, 8'h0e);
    apb(1'b0, 12'h02c, 8'h00);
    `CHK("sw clear", 32'h0e, q)
    results();
  end
endmodule

`default_nettype wire
